/* File: verilog/hfr_frame_engine.v */
`timescale 1ns/1ps
`default_nettype none
`include "hfr_defs.vh"
module hfr_frame_engine #(
	parameter RX_FIFO_DEPTH = 4,
	parameter RX_FIFO_AW    = 2
) (
	input  wire       clk_sys,
	input  wire       reset_n,
	input  wire       link_clk,
	input  wire       rxd,
	output reg        txd,
	input  wire       cmd_channel_reset,
	input  wire       cmd_rx_enable,
	input  wire       cmd_rx_disable,
	input  wire       cmd_rx_reset,
	input  wire       cmd_tx_enable,
	input  wire       cmd_tx_reset,
	input  wire       cmd_end_of_message,
	input  wire       crc_check_enable,
	input  wire [1:0] crc_preset_field,
	input  wire [1:0] address_check_mode_field,
	input  wire [7:0] address_value_reg_a,
	input  wire [7:0] address_value_reg_b,
	input  wire       underrun_action_select,
	input  wire       tx_wr_valid,
	input  wire [7:0] tx_wr_data,
	input  wire       tx_wr_block_end,
	output wire       transmit_ready_flag,
	output reg        underrun_flag,
	input  wire       clear_underrun,
	input  wire       rx_rd_pop,
	output wire       rx_rd_valid,
	output wire [7:0] rx_rd_data,
	output wire [2:0] rx_rd_status,
	output reg        end_of_message_flag,
	output reg        crc_error_flag,
	output reg        overrun_flag,
	input  wire       clear_end_of_message,
	input  wire       clear_crc_error,
	input  wire       clear_overrun,
	output reg        rx_frame_end,
	output reg        rx_short_frame,
	output reg        rx_abort_seen,
	output wire       rx_enabled,
	output wire       tx_active
);
	localparam [4:0] RX_DIS   = 5'h01;
	localparam [4:0] RX_FLAGW = 5'h02;
	localparam [4:0] RX_CHARW = 5'h04;
	localparam [4:0] RX_ADDR  = 5'h08;
	localparam [4:0] RX_RECV  = 5'h10;
	localparam [6:0] TX_DIS   = 7'h01;
	localparam [6:0] TX_IDLE  = 7'h02;
	localparam [6:0] TX_OPEN  = 7'h04;
	localparam [6:0] TX_DATA  = 7'h08;
	localparam [6:0] TX_FCS   = 7'h10;
	localparam [6:0] TX_CLOSE = 7'h20;
	localparam [6:0] TX_ABORT = 7'h40;

	reg  [1:0]  link_sync;
	reg  [1:0]  rxd_sync;
	reg         link_prev;
	reg  [4:0]  rx_state;
	reg  [7:0]  rx_raw;
	reg  [7:0]  rx_char;
	reg  [2:0]  rx_ones;
	reg  [2:0]  rx_bits;
	reg  [7:0]  addr_a1;
	reg  [7:0]  pipe0;
	reg  [7:0]  pipe1;
	reg  [7:0]  pipe2;
	reg  [1:0]  pcnt;
	reg  [1:0]  drain;
	reg  [1:0]  post;
	reg         crc_bad;
	reg         fifo_wr;
	reg  [7:0]  fifo_wdata;
	reg  [2:0]  fifo_wstat;
	reg         rx_crc_init;
	reg         rx_crc_load;
	reg  [7:0]  rx_crc_data;
	wire [15:0] rx_crc;
	reg  [6:0]  tx_state;
	reg  [7:0]  txb_data;
	reg         txb_full;
	reg         txb_last;
	reg         eom_pending;
	reg         cur_last;
	reg  [15:0] tx_sh;
	reg  [3:0]  tx_bits;
	reg  [3:0]  tx_len_m1;
	reg  [2:0]  tx_ones;
	reg         tx_crc_init;
	reg         tx_crc_load;
	reg  [7:0]  tx_crc_data;
	wire [15:0] tx_crc;
	wire        fifo_head;

	wire link_rise = link_sync[1] & ~link_prev;
	wire link_fall = ~link_sync[1] & link_prev;
	wire rx_bit    = rxd_sync[1];
	wire preset_ones = (crc_preset_field == `HFR_CRC_PRESET_ONES);
	wire rx_kill = cmd_channel_reset | cmd_rx_reset | cmd_rx_disable;
	wire tx_kill = cmd_channel_reset | cmd_tx_reset;

	wire [7:0] raw_next  = {rx_bit, rx_raw[7:1]};
	wire [7:0] char_next = {rx_bit, rx_char[7:1]};
	wire is_flag  = (raw_next == `HFR_FLAG);
	wire is_abort = rx_bit && (rx_ones == `HFR_ABORT_RUN);
	wire is_stuff = !rx_bit && (rx_ones == `HFR_STUFF_RUN);
	wire byte_done = !is_stuff && (rx_bits == `HFR_BYTE_LAST);

	wire sa1_ok = (char_next == address_value_reg_a) ||
		(char_next == `HFR_GLOBAL_ADDR);
	wire sa2_ok = (char_next == address_value_reg_b) ||
		(char_next == `HFR_GLOBAL_ADDR);
	wire dual_ok = ((addr_a1 == address_value_reg_a) &&
		(char_next == address_value_reg_b)) ||
		((addr_a1 == `HFR_GLOBAL_ADDR) && sa2_ok);
	wire a2_ok = (address_check_mode_field == `HFR_MODE_DUAL) ? dual_ok : sa2_ok;
	wire reject = ((rx_state == RX_CHARW) && !sa1_ok &&
		(address_check_mode_field == `HFR_MODE_SINGLE1)) ||
		((rx_state == RX_ADDR) && !a2_ok);

	assign rx_enabled = (rx_state != RX_DIS);
	assign tx_active  = (tx_state != TX_DIS) && (tx_state != TX_IDLE);
	assign transmit_ready_flag = (tx_state != TX_DIS) && !txb_full &&
		!underrun_flag;
	wire tx_take = tx_wr_valid && transmit_ready_flag;

	function [15:0] rev16;
		input [15:0] v;
		integer k;
		begin
			for (k = 0; k < 16; k = k + 1)
				rev16[k] = v[15 - k];
		end
	endfunction

	hfr_crc16 u_rx_crc (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.init        (rx_crc_init),
		.preset_ones (preset_ones),
		.load        (rx_crc_load),
		.data        (rx_crc_data),
		.crc         (rx_crc)
	);

	hfr_crc16 u_tx_crc (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.init        (tx_crc_init),
		.preset_ones (preset_ones),
		.load        (tx_crc_load),
		.data        (tx_crc_data),
		.crc         (tx_crc)
	);

	hfr_rx_fifo #(
		.DEPTH (RX_FIFO_DEPTH),
		.AW    (RX_FIFO_AW)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.flush     (cmd_channel_reset | cmd_rx_reset),
		.wr_en     (fifo_wr),
		.wr_data   (fifo_wdata),
		.wr_stat   (fifo_wstat),
		.rd_pop    (rx_rd_pop),
		.rd_valid  (rx_rd_valid),
		.rd_data   (rx_rd_data),
		.rd_stat   (rx_rd_status),
		.head_load (fifo_head)
	);

	// The line clock is only sampled; its edges become one-cycle strobes.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			link_sync <= 2'h0;
			rxd_sync  <= 2'h3;
			link_prev <= 1'b0;
		end else begin
			link_sync <= {link_sync[0], link_clk};
			rxd_sync  <= {rxd_sync[0], rxd};
			link_prev <= link_sync[1];
		end
	end

	// Receive engine. Three bytes are held back so the FCS can be dropped
	// at the closing flag; the drain takes one cycle, three with checking off, far below a bit time.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_state <= RX_DIS;
			rx_raw <= 8'h00;
			rx_char <= 8'h00;
			rx_ones <= 3'h0;
			rx_bits <= 3'h0;
			addr_a1 <= 8'h00;
			pipe0 <= 8'h00;
			pipe1 <= 8'h00;
			pipe2 <= 8'h00;
			pcnt <= 2'h0;
			drain <= 2'h0;
			crc_bad <= 1'b0;
			post <= 2'h0;
			fifo_wr <= 1'b0;
			fifo_wdata <= 8'h00;
			fifo_wstat <= `HFR_ST_NONE;
			rx_crc_init <= 1'b0;
			rx_crc_load <= 1'b0;
			rx_crc_data <= 8'h00;
			rx_short_frame <= 1'b0;
			rx_abort_seen <= 1'b0;
		end else begin
			fifo_wr <= 1'b0;
			rx_crc_init <= 1'b0;
			rx_crc_load <= 1'b0;
			rx_short_frame <= 1'b0;
			rx_abort_seen <= 1'b0;
			if (rx_kill) begin
				rx_state <= RX_DIS;
				pcnt <= 2'h0;
				drain <= 2'h0;
			end else if (drain != 2'h0) begin
				fifo_wr <= 1'b1;
				fifo_wdata <= pipe0;
				fifo_wstat <= (drain == 2'h1) ? (`HFR_ST_EOM |
					((crc_check_enable && crc_bad) ? `HFR_ST_CRC_ERROR_FLAG :
					`HFR_ST_NONE)) : `HFR_ST_NONE;
				pipe0 <= pipe1;
				pipe1 <= pipe2;
				drain <= drain - 2'h1;
			end else if (rx_state == RX_DIS) begin
				if (cmd_rx_enable)
					rx_state <= RX_FLAGW;
			end else if (link_rise) begin
				rx_raw <= raw_next;
				rx_ones <= !rx_bit ? 3'h0 : (rx_ones == `HFR_ONES_MAX) ?
					`HFR_ONES_MAX : rx_ones + 3'h1;
				if (!is_stuff) begin
					rx_char <= char_next;
					rx_bits <= rx_bits + 3'h1;
				end
				if (is_abort) begin
					rx_abort_seen <= (rx_state != RX_FLAGW);
					rx_state <= RX_FLAGW;
					pcnt <= 2'h0;
				end else if (is_flag) begin
					rx_bits <= 3'h0;
					rx_crc_init <= 1'b1;
					rx_state <= RX_CHARW;
					pcnt <= 2'h0;
					crc_bad <= (rx_crc != `HFR_CRC_ZERO);
					if (rx_state == RX_RECV && post == `HFR_RX_DELAY)
						drain <= crc_check_enable ? `HFR_DRAIN_CHECKED :
							`HFR_RX_DELAY;
					else if (rx_state == RX_RECV || rx_state == RX_ADDR)
						rx_short_frame <= 1'b1;
				end else if (byte_done && rx_state != RX_FLAGW) begin
					if (reject) begin
						rx_state <= RX_FLAGW;
						pcnt <= 2'h0;
					end else begin
						rx_crc_load <= 1'b1;
						rx_crc_data <= char_next;
						post <= (rx_state != RX_RECV) ? 2'h0 :
							post + {1'b0, post != `HFR_RX_DELAY};
						if (pcnt == `HFR_RX_DELAY) begin
							fifo_wr <= 1'b1;
							fifo_wdata <= pipe0;
							fifo_wstat <= `HFR_ST_NONE;
							pipe0 <= pipe1;
							pipe1 <= pipe2;
							pipe2 <= char_next;
						end else begin
							if (pcnt == 2'h0)
								pipe0 <= char_next;
							else if (pcnt == 2'h1)
								pipe1 <= char_next;
							else
								pipe2 <= char_next;
							pcnt <= pcnt + 2'h1;
						end
						if (rx_state == RX_CHARW) begin
							addr_a1 <= char_next;
							if (address_check_mode_field == `HFR_MODE_NOCHECK ||
								address_check_mode_field == `HFR_MODE_SINGLE1)
								rx_state <= RX_RECV;
							else
								rx_state <= RX_ADDR;
						end else begin
							rx_state <= RX_RECV;
						end
					end
				end
			end
		end
	end

	// Status flags latch as the matching byte reaches the read register.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			end_of_message_flag <= 1'b0;
			crc_error_flag <= 1'b0;
			overrun_flag <= 1'b0;
			rx_frame_end <= 1'b0;
		end else begin
			rx_frame_end <= fifo_head && ((rx_rd_status & `HFR_ST_EOM) != 3'h0);
			if (clear_end_of_message || cmd_channel_reset)
				end_of_message_flag <= 1'b0;
			if (clear_crc_error || cmd_channel_reset)
				crc_error_flag <= 1'b0;
			if (clear_overrun || cmd_channel_reset)
				overrun_flag <= 1'b0;
			if (fifo_head) begin
				if ((rx_rd_status & `HFR_ST_EOM) != 3'h0)
					end_of_message_flag <= 1'b1;
				if ((rx_rd_status & `HFR_ST_CRC_ERROR_FLAG) != 3'h0)
					crc_error_flag <= 1'b1;
				if ((rx_rd_status & `HFR_ST_OVERRUN_FLAG) != 3'h0)
					overrun_flag <= 1'b1;
			end
		end
	end

	// Transmit engine: one shift register serves flags, bytes, FCS and abort.
	task load_unit;
		input [15:0] value;
		input [3:0]  len_m1;
		begin
			tx_sh <= value;
			tx_len_m1 <= len_m1;
			tx_bits <= 4'h0;
		end
	endtask

	task end_frame;
		begin
			if (crc_check_enable) begin
				tx_state <= TX_FCS;
				load_unit(rev16(tx_crc), `HFR_UNIT_FCS);
			end else begin
				tx_state <= TX_CLOSE;
				load_unit({8'h00, `HFR_FLAG}, `HFR_UNIT_BYTE);
			end
		end
	endtask

	task next_byte;
		begin
			load_unit({8'h00, txb_data}, `HFR_UNIT_BYTE);
			cur_last <= txb_last;
			txb_full <= 1'b0;
			tx_crc_load <= 1'b1;
			tx_crc_data <= txb_data;
		end
	endtask

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_state <= TX_DIS;
			txd <= 1'b1;
			txb_data <= 8'h00;
			txb_full <= 1'b0;
			txb_last <= 1'b0;
			eom_pending <= 1'b0;
			cur_last <= 1'b0;
			tx_sh <= 16'h0000;
			tx_bits <= 4'h0;
			tx_len_m1 <= 4'h0;
			tx_ones <= 3'h0;
			tx_crc_init <= 1'b0;
			tx_crc_load <= 1'b0;
			tx_crc_data <= 8'h00;
			underrun_flag <= 1'b0;
		end else begin
			tx_crc_init <= 1'b0;
			tx_crc_load <= 1'b0;
			if (clear_underrun || cmd_channel_reset)
				underrun_flag <= 1'b0;
			if (cmd_end_of_message)
				eom_pending <= 1'b1;
			if (tx_kill) begin
				tx_state <= TX_DIS;
				txd <= 1'b1;
				txb_full <= 1'b0;
				eom_pending <= 1'b0;
			end else if (tx_state == TX_DIS) begin
				if (cmd_tx_enable)
					tx_state <= TX_IDLE;
			end else if (link_fall) begin
				if (tx_state == TX_IDLE) begin
					txd <= 1'b1;
					if (txb_full && !underrun_flag) begin
						tx_state <= TX_OPEN;
						tx_crc_init <= 1'b1;
						load_unit({8'h00, `HFR_FLAG}, `HFR_UNIT_BYTE);
					end
				end else if ((tx_state == TX_DATA || tx_state == TX_FCS) &&
					tx_ones == `HFR_STUFF_RUN) begin
					txd <= 1'b0;
					tx_ones <= 3'h0;
				end else begin
					txd <= tx_sh[0];
					tx_sh <= {1'b0, tx_sh[15:1]};
					tx_ones <= tx_sh[0] ? tx_ones + 3'h1 : 3'h0;
					tx_bits <= tx_bits + 4'h1;
					if (tx_bits == tx_len_m1) begin
						case (tx_state)
						TX_OPEN: begin
							tx_state <= TX_DATA;
							next_byte;
						end
						TX_DATA: begin
							if (cur_last) begin
								end_frame;
							end else if (txb_full) begin
								next_byte;
							end else if (eom_pending) begin
								eom_pending <= 1'b0;
								end_frame;
							end else begin
								underrun_flag <= 1'b1;
								if (!underrun_action_select) begin
									tx_state <= TX_ABORT;
									load_unit({8'h00, `HFR_ABORT}, `HFR_UNIT_BYTE);
								end else begin
									end_frame;
								end
							end
						end
						TX_FCS: begin
							tx_state <= TX_CLOSE;
							load_unit({8'h00, `HFR_FLAG}, `HFR_UNIT_BYTE);
						end
						TX_CLOSE: begin
							if (txb_full && !underrun_flag) begin
								tx_state <= TX_OPEN;
								tx_crc_init <= 1'b1;
								load_unit({8'h00, `HFR_FLAG}, `HFR_UNIT_BYTE);
							end else begin
								tx_state <= TX_IDLE;
							end
						end
						default: begin
							tx_state <= TX_IDLE;
							txb_full <= 1'b0;
						end
						endcase
					end
				end
			end
			if (tx_take) begin
				txb_data <= tx_wr_data;
				txb_full <= 1'b1;
				txb_last <= eom_pending || cmd_end_of_message ||
					tx_wr_block_end;
				eom_pending <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/hfr_defs.vh */
// What this block does
// - Receiver resets or disables into a state that ignores the serial input.
// - Flag moves to character wait; extra flags skipped; shared flags between frames work.
// - Matching address starts reception, mismatch returns to flag wait; no-check skips it.
// - Flag within three characters after address check is a short frame.
// - Closing flag delivers through last information byte, plus FCS when checking is off.
// - Frame check is CRC-CCITT, preset to all ones by the preset field.
// - Both CRC calculators preset just before each address field.
// - Transmit CRC covers address, control and information before zero insertion.
// - Receive CRC covers address, control and information after zero deletion.
// - CRC result rides the status FIFO to the last byte; never set when off.
// - Byte arriving into a full buffer overwrites the newest stage, clearing end status.
// - Overrun flag sets when that byte becomes readable; cleared only by software.
// - Underrun means shift register and buffer empty without an end-of-message command.
// - Underrun sends abort then idles, or ends the frame with closing flag, after FCS when checking is on.
// - Underrun sets its flag and holds transmit ready low while it stays set.
// - End of message comes from command, block-end byte, or underrun with normal end.
// - Last byte: first after command, block-end byte, or the byte before underrun.
// - After the last byte send closing flag if checking is off, else FCS.
// - End and CRC status reach the flags as the last byte becomes readable.
// - Bytes reach the buffer three characters late so FCS can be stripped.
// - Address modes: no-check, first byte match, second byte match, or FFh.
// - Dual mode accepts both matched, both global, or group with first byte FFh.
// - Frame boundaries are found only by the flag pattern 01111110.
// - Abort on underrun when action select is 0; abort is eight ones.
`ifndef HFR_DEFS_VH
`define HFR_DEFS_VH
`define HFR_FLAG          8'h7E
`define HFR_ABORT         8'hFF
`define HFR_GLOBAL_ADDR   8'hFF
`define HFR_MODE_NOCHECK  2'h0
`define HFR_MODE_SINGLE1  2'h1
`define HFR_MODE_SINGLE2  2'h2
`define HFR_MODE_DUAL     2'h3
`define HFR_CRC_POLY      16'h1021
`define HFR_CRC_ONES      16'hFFFF
`define HFR_CRC_ZERO      16'h0000
`define HFR_CRC_PRESET_ONES 2'h0
`define HFR_ST_EOM        3'h1
`define HFR_ST_CRC_ERROR_FLAG       3'h2
`define HFR_ST_OVERRUN_FLAG       3'h4
`define HFR_ST_NONE       3'h0
`define HFR_STUFF_RUN     3'h5
`define HFR_ABORT_RUN     3'h6
`define HFR_ONES_MAX      3'h7
`define HFR_BYTE_LAST     3'h7
`define HFR_UNIT_BYTE     4'h7
`define HFR_UNIT_FCS      4'hF
`define HFR_RX_DELAY      2'h3
`define HFR_DRAIN_CHECKED 2'h1
`endif

/* File: verilog/hfr_crc16.v */
`timescale 1ns/1ps
`default_nettype none
`include "hfr_defs.vh"
module hfr_crc16 (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        init,
	input  wire        preset_ones,
	input  wire        load,
	input  wire [7:0]  data,
	output reg  [15:0] crc
);
	reg [15:0] next_crc;
	integer    i;

	// Bits enter least significant first, the order they travel on the line.
	always @* begin
		next_crc = crc;
		for (i = 0; i < 8; i = i + 1) begin
			if (next_crc[15] ^ data[i])
				next_crc = {next_crc[14:0], 1'b0} ^ `HFR_CRC_POLY;
			else
				next_crc = {next_crc[14:0], 1'b0};
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			crc <= `HFR_CRC_ONES;
		else if (init)
			crc <= preset_ones ? `HFR_CRC_ONES : `HFR_CRC_ZERO;
		else if (load)
			crc <= next_crc;
	end
endmodule
`default_nettype wire

/* File: verilog/hfr_rx_fifo.v */
`timescale 1ns/1ps
`default_nettype none
`include "hfr_defs.vh"
module hfr_rx_fifo #(
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire       clk_sys,
	input  wire       reset_n,
	input  wire       flush,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	input  wire [2:0] wr_stat,
	input  wire       rd_pop,
	output reg        rd_valid,
	output reg  [7:0] rd_data,
	output reg  [2:0] rd_stat,
	output reg        head_load
);
	localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
	reg  [7:0]  mem_d [0:DEPTH-1];
	reg  [2:0]  mem_s [0:DEPTH-1];
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	reg  [AW:0]   count;
	wire [AW-1:0] top_ptr = wr_ptr - 1'b1;
	wire          mem_rd  = (count != 0) && (!rd_valid || rd_pop);
	wire          over    = wr_en && (count == FULL_COUNT) && !mem_rd;
	wire          put     = wr_en && !over;

	// Byte and status share one pointer, so they can never drift apart.
	always @(posedge clk_sys) begin
		if (over) begin
			mem_d[top_ptr] <= wr_data;
			mem_s[top_ptr] <= (wr_stat & ~`HFR_ST_EOM) | `HFR_ST_OVERRUN_FLAG;
		end else if (put) begin
			mem_d[wr_ptr] <= wr_data;
			mem_s[wr_ptr] <= wr_stat;
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr    <= {AW{1'b0}};
			rd_ptr    <= {AW{1'b0}};
			count     <= {(AW+1){1'b0}};
			rd_valid  <= 1'b0;
			rd_data   <= 8'h00;
			rd_stat   <= `HFR_ST_NONE;
			head_load <= 1'b0;
		end else if (flush) begin
			wr_ptr    <= {AW{1'b0}};
			rd_ptr    <= {AW{1'b0}};
			count     <= {(AW+1){1'b0}};
			rd_valid  <= 1'b0;
			head_load <= 1'b0;
		end else begin
			head_load <= mem_rd;
			if (put)
				wr_ptr <= wr_ptr + 1'b1;
			if (mem_rd) begin
				rd_data  <= mem_d[rd_ptr];
				rd_stat  <= mem_s[rd_ptr];
				rd_valid <= 1'b1;
				rd_ptr   <= rd_ptr + 1'b1;
			end else if (rd_pop) begin
				rd_valid <= 1'b0;
			end
			if (put && !mem_rd)
				count <= count + 1'b1;
			else if (!put && mem_rd)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/hfr_engine_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module hfr_engine_monitor (
	input wire logic       clk_sys,
	input wire logic       reset_n,
	input wire logic       rx_enabled,
	input wire logic       rx_short_frame,
	input wire logic       transmit_ready_flag,
	input wire logic       underrun_flag,
	input wire logic       clear_underrun,
	input wire logic       cmd_channel_reset,
	input wire logic       overrun_flag,
	input wire logic       clear_overrun,
	input wire logic       rx_rd_valid,
	input wire logic [2:0] rx_rd_status,
	input wire logic       end_of_message_flag,
	input wire logic       crc_error_flag,
	input wire logic       rx_frame_end
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_RX_OFF: assert property (
		!rx_enabled [*3] |-> !rx_short_frame)
		else $error("short frame reported while disabled");
	AST_UDR_READY: assert property (
		underrun_flag |-> !transmit_ready_flag)
		else $error("ready high during underrun");
	AST_UDR_HOLD: assert property (
		underrun_flag && !clear_underrun && !cmd_channel_reset
		|=> underrun_flag)
		else $error("underrun flag dropped by itself");
	AST_UDR_EMPTY: assert property (
		$rose(underrun_flag) |-> $past(transmit_ready_flag))
		else $error("underrun with a byte in the buffer");
	AST_OVR_HOLD: assert property (
		overrun_flag && !clear_overrun && !cmd_channel_reset
		|=> overrun_flag)
		else $error("overrun flag dropped by itself");
	AST_OVR_SET: assert property (
		$rose(overrun_flag) |-> $past(rx_rd_valid && rx_rd_status[2]))
		else $error("overrun flag without overrun byte readable");
	AST_EOM_SET: assert property (
		$rose(end_of_message_flag)
		|-> $past(rx_rd_valid && rx_rd_status[0]))
		else $error("end flag without end byte readable");
	AST_CRC_SET: assert property (
		$rose(crc_error_flag) |-> $past(rx_rd_valid && rx_rd_status[1]))
		else $error("crc flag without bad byte readable");
	AST_FRAME_END: assert property (
		rx_frame_end |-> end_of_message_flag
		&& $past(rx_rd_valid && rx_rd_status[0]))
		else $error("frame end notice out of step");
	cover property ($rose(underrun_flag));
	cover property ($rose(overrun_flag));
	cover property (rx_frame_end && crc_error_flag);
	cover property (rx_short_frame);
endmodule
bind hfr_frame_engine hfr_engine_monitor u_mon (.clk_sys, .reset_n,
	.rx_enabled, .rx_short_frame, .transmit_ready_flag, .underrun_flag,
	.clear_underrun, .cmd_channel_reset, .overrun_flag, .clear_overrun,
	.rx_rd_valid, .rx_rd_status, .end_of_message_flag, .crc_error_flag,
	.rx_frame_end);
`default_nettype wire

/* File: verification/hfr_station.sv */
`timescale 1ns/1ps
`default_nettype none
module hfr_station (
	output var logic link_clk,
	output var logic rxd,
	input  wire logic txd
);
	logic [15:0] crc;
	logic [15:0] fcs;
	logic        fb;
	int          rones;
	int          tones;
	int          flags_seen;
	initial begin
		link_clk = 1'b0;
		rxd = 1'b1;
		rones = 0;
		tones = 0;
		flags_seen = 0;
	end
	// The clock runs only inside these tasks, as a real line would stop.
	task automatic bit_out(input logic b);
		rxd = b;
		#80 link_clk = 1'b1;
		if (txd === 1'b1)
			tones++;
		else begin
			if (tones == 6)
				flags_seen++;
			tones = 0;
		end
		#80 link_clk = 1'b0;
	endtask
	task automatic sbit(input logic b);
		bit_out(b);
		rones = b ? rones + 1 : 0;
		if (rones == 5) begin
			bit_out(1'b0);
			rones = 0;
		end
	endtask
	task automatic flag();
		for (int i = 0; i < 8; i++)
			bit_out(i != 0 && i != 7);
		rones = 0;
	endtask
	task automatic body(input logic [7:0] q[$], input logic bad);
		crc = 16'hFFFF;
		foreach (q[k])
			for (int i = 0; i < 8; i++) begin
				sbit(q[k][i]);
				fb = crc[15] ^ q[k][i];
				crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0);
			end
		fcs = crc ^ {15'h0000, bad};
		for (int i = 15; i >= 0; i--)
			sbit(fcs[i]);
	endtask
	task automatic idle(input int n);
		repeat (n) bit_out(1'b1);
	endtask
endmodule
`default_nettype wire

/* File: verification/hdlc_frame_rx_tx_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hdlc_frame_rx_tx_control_tb;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [10:0] cmd = 11'h000;
	logic        crc_on = 1'b1;
	logic [1:0]  mode = 2'h0;
	logic        act = 1'b0;
	logic        wr_v = 1'b0;
	logic [7:0]  wr_d = 8'h00;
	logic        wr_e = 1'b0;
	logic        pop = 1'b0;
	logic        seen_short = 1'b0;
	logic [7:0]  f1;
	wire         link_clk, rxd, txd, ready, udr, rv, eomf, crcf, ovrf;
	wire         fend, shrt, ren;
	wire  [7:0]  rd;
	wire  [2:0]  rs;
	int          n_fail = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          f0;
	logic [18:0] tab [10] = '{{2'h1, 8'h5A, 8'h00, 1'b1},
		{2'h1, 8'hFF, 8'h00, 1'b1}, {2'h1, 8'h33, 8'h00, 1'b0},
		{2'h2, 8'h00, 8'h6B, 1'b1}, {2'h2, 8'h00, 8'hFF, 1'b1},
		{2'h2, 8'h00, 8'h11, 1'b0}, {2'h3, 8'h5A, 8'h6B, 1'b1},
		{2'h3, 8'hFF, 8'hFF, 1'b1}, {2'h3, 8'hFF, 8'h6B, 1'b1},
		{2'h3, 8'h5A, 8'h11, 1'b0}};
	hfr_station st (.link_clk(link_clk), .rxd(rxd), .txd(txd));
	hfr_frame_engine dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.link_clk(link_clk), .rxd(rxd), .txd(txd),
		.cmd_channel_reset(cmd[0]), .cmd_rx_enable(cmd[1]),
		.cmd_rx_disable(cmd[2]), .cmd_rx_reset(cmd[3]),
		.cmd_tx_enable(cmd[4]), .cmd_tx_reset(cmd[5]),
		.cmd_end_of_message(cmd[6]), .crc_check_enable(crc_on),
		.crc_preset_field(2'h0), .address_check_mode_field(mode),
		.address_value_reg_a(8'h5A), .address_value_reg_b(8'h6B),
		.underrun_action_select(act), .tx_wr_valid(wr_v),
		.tx_wr_data(wr_d), .tx_wr_block_end(wr_e),
		.transmit_ready_flag(ready), .underrun_flag(udr),
		.clear_underrun(cmd[7]), .rx_rd_pop(pop), .rx_rd_valid(rv),
		.rx_rd_data(rd), .rx_rd_status(rs), .end_of_message_flag(eomf),
		.crc_error_flag(crcf), .overrun_flag(ovrf),
		.clear_end_of_message(cmd[8]), .clear_crc_error(cmd[9]),
		.clear_overrun(cmd[10]), .rx_frame_end(fend),
		.rx_short_frame(shrt), .rx_abort_seen(), .rx_enabled(ren),
		.tx_active());
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (shrt === 1'b1)
			seen_short <= 1'b1;
		cyc++;
		// Well past the expected run of about 27000 cycles.
		if (cyc == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(int i);
		@(posedge clk_sys) cmd[i] <= 1'b1;
		@(posedge clk_sys) cmd[i] <= 1'b0;
	endtask
	task automatic take(logic [7:0] ed, logic [2:0] es);
		int n;
		n = 0;
		do @(posedge clk_sys); while (rv !== 1'b1 && ++n < 1000);
		chk("rx valid", 1, rv);
		chk("rx byte", ed, rd);
		chk("rx status", es, rs);
		pop <= 1'b1;
		@(posedge clk_sys) pop <= 1'b0;
	endtask
	task automatic wr(logic [7:0] d, logic e);
		int n;
		n = 0;
		do @(posedge clk_sys); while (ready !== 1'b1 && ++n < 4000);
		wr_v <= 1'b1;
		wr_d <= d;
		wr_e <= e;
		@(posedge clk_sys) wr_v <= 1'b0;
	endtask
	task automatic rxf(logic [7:0] q[$], logic bad);
		st.flag();
		st.body(q, bad);
		st.flag();
		repeat (20) @(posedge clk_sys);
	endtask
	task automatic t_reset();
		chk("txd idle", 1, txd);
		chk("rx enabled", 0, ren);
		chk("tx ready", 0, ready);
		rxf({8'h12, 8'h34, 8'h56}, 0);
		chk("rx while off", 0, rv);
	endtask
	task automatic t_rx_good();
		logic [7:0] e [6] = '{8'h12, 8'hFF, 8'h7E, 8'hC3, 8'h00, 8'h81};
		pulse(1);
		fork
			begin
				st.flag();
				rxf({8'h12, 8'hFF, 8'h7E}, 0);
				st.body({8'hC3, 8'h00, 8'h81}, 0);
				st.flag();
			end
			for (int i = 0; i < 6; i++)
				take(e[i], (i % 3 == 2) ? 3'h1 : 3'h0);
		join
		chk("eom flag", 1, eomf);
		chk("crc flag", 0, crcf);
		pulse(8);
	endtask
	task automatic t_crc_off();
		rxf({8'h21, 8'h43, 8'h65}, 1);
		take(8'h21, 0);
		take(8'h43, 0);
		take(8'h65, 3'h3);
		chk("crc flag bad", 1, crcf);
		pulse(9);
		@(posedge clk_sys) crc_on <= 1'b0;
		rxf({8'h21, 8'h43, 8'h65}, 0);
		take(8'h21, 0);
		take(8'h43, 0);
		take(8'h65, 0);
		f1 = {<<{st.fcs[15:8]}};
		take(f1, 0);
		f1 = {<<{st.fcs[7:0]}};
		take(f1, 3'h1);
		chk("crc flag off", 0, crcf);
		crc_on <= 1'b1;
		pulse(8);
	endtask
	task automatic t_addr();
		foreach (tab[i]) begin
			@(posedge clk_sys) mode <= tab[i][18:17];
			rxf({tab[i][16:9], tab[i][8:1], 8'h9C, 8'h9D}, 0);
			if (tab[i][0]) begin
				take(tab[i][16:9], 0);
				take(tab[i][8:1], 0);
				take(8'h9C, 0);
				take(8'h9D, 3'h1);
			end else
				chk("addr drop", 0, rv);
		end
	endtask
	task automatic t_short();
		seen_short = 1'b0;
		@(posedge clk_sys) mode <= 2'h1;
		rxf({8'h5A}, 0);
		chk("short seen", 1, seen_short);
		chk("short drop", 0, rv);
		mode <= 2'h0;
	endtask
	task automatic t_overrun();
		rxf({8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08}, 0);
		for (int i = 1; i < 5; i++)
			take(i[7:0], 0);
		take(8'h08, 3'h4);
		chk("ovr flag", 1, ovrf);
		rxf({8'h11, 8'h22}, 0);
		take(8'h11, 0);
		take(8'h22, 3'h1);
		chk("ovr sticky", 1, ovrf);
		pulse(10);
		@(posedge clk_sys);
		chk("ovr clear", 0, ovrf);
		pulse(8);
	endtask
	// Each transmit case counts flags seen on the line; one means abort.
	task automatic t_tx(int kind, int nflag, logic eu);
		f0 = st.flags_seen;
		fork
			st.idle(130);
			begin
				wr(8'hA1, 0);
				if (kind == 0)
					pulse(6);
				if (kind < 2)
					wr(8'hB2, kind[0]);
			end
		join
		chk("tx flags", 16'(nflag), 16'(st.flags_seen - f0));
		chk("underrun", eu, udr);
		if (eu) begin
			chk("ready held", 0, ready);
			pulse(7);
			@(posedge clk_sys);
			chk("ready back", 1, ready);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_rx_good();
		t_crc_off();
		t_addr();
		t_short();
		t_overrun();
		pulse(4);
		@(posedge clk_sys);
		chk("tx ready", 1, ready);
		t_tx(0, 2, 0);
		t_tx(1, 2, 0);
		t_tx(2, 1, 1);
		act <= 1'b1;
		t_tx(2, 2, 1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
